/* File: rtl/thr_reporter.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - 16-bit external value replaces configured threshold
// - 8-bit external value replaces configured threshold
// - teach pulse stores current measurement as threshold
// - download discards external value until fresh one
// - change to 1 applied after switch-on delay
// - previous 0 repeated while on-delay runs
// - change to 0 applied after switch-off delay
// - previous 1 repeated while off-delay runs
// - silent condition also suppresses cyclic sends
// - no change sends when disabled; cyclic still
// - send-on-change sends every non-silent 0/1 transition
// - both disabled means never sent
// - cycle period is setting times ten seconds
// - threshold in 25 lux steps, 25..650
// - hysteresis from none, 5 up to 600
// - exceed modes: above sets, below minus hysteresis resets
// - undershoot modes: below sets, above plus hysteresis resets
// - hysteresis-silent modes send only primary crossing
// - primary-silent modes send only hysteresis crossing
// - zero, one or two thresholds; unused inactive
// - measured value sent on step change, 10 s delay
// - step relative to range top value
module thr_reporter #(
	parameter int unsigned  SEC_CYCLES = thr_pkg::SEC_CYCLES,
	parameter logic [15:0]  RANGE_TOP  = thr_pkg::RANGE_TOP_RST
) (
	input  wire logic                         ref_clk,
	input  wire logic                         rst,
	input  wire logic [thr_pkg::AW-1:0]       reg_addr,
	input  wire logic [thr_pkg::DW-1:0]       reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output wire logic [thr_pkg::DW-1:0]       reg_rdata,
	input  wire logic                         meas_valid,
	input  wire logic [thr_pkg::DW-1:0]       meas_value,
	input  wire logic [thr_pkg::THR_COUNT-1:0] ext_wr,
	input  wire logic [thr_pkg::DW-1:0]       ext_value,
	input  wire logic [thr_pkg::THR_COUNT-1:0] teach_sw,
	output wire logic [thr_pkg::THR_COUNT-1:0] obj_send,
	output wire logic [thr_pkg::THR_COUNT-1:0] obj_value,
	output logic                              meas_send,
	output logic [thr_pkg::DW-1:0]            meas_out
);
	localparam int SECW = $clog2(SEC_CYCLES + 1);
	localparam int NT   = thr_pkg::THR_COUNT;

	thr_cfg_if cfg_bus ();

	thr_regfile u_regfile (
		.ref_clk (ref_clk),
		.rst     (rst),
		.bus     (cfg_bus.mem)
	);

	logic [thr_pkg::DW-1:0] ctrl_w;
	logic [1:0]             limits;
	logic [1:0]             diff_sel;
	logic                   load_ff;
	logic [SECW-1:0]        sec_cnt_ff;
	logic                   sec_tick_ff;
	logic [thr_pkg::DW-1:0] meas_ff;
	logic                   meas_new_ff;
	wire logic [NT-1:0]     obj_v;
	wire logic [NT-1:0]     cond_v;
	wire logic [NT-1:0]     extv_v;
	wire logic [NT-1:0]     wait_v;
	wire logic [NT-1:0][thr_pkg::DW-1:0] thr_v;

	// register port; the load bit is a command and is never stored
	assign cfg_bus.wr    = reg_wr;
	assign cfg_bus.rd    = reg_rd;
	assign cfg_bus.addr  = reg_addr;
	assign cfg_bus.wdata = (reg_addr == thr_pkg::REG_CTRL) ?
		(reg_wdata & ~(16'h0001 << thr_pkg::CTRL_LOAD_BIT)) : reg_wdata;
	assign reg_rdata     = cfg_bus.rdata;

	// read-only words showing block state
	assign cfg_bus.stat[0] = {8'h00, wait_v, extv_v, cond_v, obj_v};
	assign cfg_bus.stat[1] = thr_v[0];
	assign cfg_bus.stat[2] = thr_v[1];

	assign ctrl_w   = cfg_bus.cfg[thr_pkg::REG_CTRL];
	assign limits   = ctrl_w[thr_pkg::CTRL_LIMITS_LSB +: 2];
	assign diff_sel = ctrl_w[thr_pkg::CTRL_DIFF_LSB +: 2];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			load_ff <= 1'b0;
		end else begin
			load_ff <= reg_wr && reg_addr == thr_pkg::REG_CTRL &&
				reg_wdata[thr_pkg::CTRL_LOAD_BIT];
		end
	end

	// one-second enable; every timer below counts these ticks
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sec_cnt_ff  <= '0;
			sec_tick_ff <= 1'b0;
		end else if (sec_cnt_ff == SECW'(SEC_CYCLES - 1)) begin
			sec_cnt_ff  <= '0;
			sec_tick_ff <= 1'b1;
		end else begin
			sec_cnt_ff  <= SECW'(sec_cnt_ff + 1'b1);
			sec_tick_ff <= 1'b0;
		end
	end

	// latest measurement and its arrival pulse
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meas_ff     <= '0;
			meas_new_ff <= 1'b0;
		end else begin
			meas_new_ff <= meas_valid;
			if (meas_valid) begin
				meas_ff <= meas_value;
			end
		end
	end

	// measured-value reporting
	logic [31:0]            step_wide;
	logic [thr_pkg::DW-1:0] step;
	logic [thr_pkg::DW-1:0] last_sent_ff;
	logic [thr_pkg::DW-1:0] meas_diff;
	logic [3:0]             gap_ff;

	// step from range top, never below one count
	always_comb begin
		case (diff_sel)
			2'h0: step_wide = (32'(RANGE_TOP) * thr_pkg::DIFF_PM0) / thr_pkg::PM_DIV;
			2'h1: step_wide = (32'(RANGE_TOP) * thr_pkg::DIFF_PM1) / thr_pkg::PM_DIV;
			2'h2: step_wide = (32'(RANGE_TOP) * thr_pkg::DIFF_PM2) / thr_pkg::PM_DIV;
			default: step_wide = (32'(RANGE_TOP) * thr_pkg::DIFF_PM3) / thr_pkg::PM_DIV;
		endcase
		step = (step_wide[15:0] == 16'h0000) ? 16'h0001 : step_wide[15:0];
	end

	assign meas_diff = (meas_ff >= last_sent_ff) ? (meas_ff - last_sent_ff) :
		(last_sent_ff - meas_ff);

	// send on step change, at least ten second ticks apart (just over 9 s)
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			last_sent_ff <= '0;
			gap_ff       <= 4'h0;
			meas_send    <= 1'b0;
			meas_out     <= '0;
		end else begin
			meas_send <= 1'b0;
			if (meas_diff >= step && gap_ff >= thr_pkg::MEAS_DELAY_S) begin
				meas_send    <= 1'b1;
				meas_out     <= meas_ff;
				last_sent_ff <= meas_ff;
				gap_ff       <= 4'h0;
			end else if (sec_tick_ff && gap_ff < thr_pkg::MEAS_DELAY_S) begin
				gap_ff <= 4'(gap_ff + 1'b1);
			end
		end
	end

	// one instance per threshold
	for (genvar g = 0; g < NT; g++) begin : g_thr
		logic [thr_pkg::DW-1:0] cfg_w;
		logic [thr_pkg::DW-1:0] tim_w;
		logic [4:0]             idx;
		logic [4:0]             idx_c;
		logic [3:0]             mode;
		logic [3:0]             on_code;
		logic [3:0]             off_code;
		logic                   soc;
		logic [6:0]             cyc;
		logic [6:0]             cyc_c;
		logic [11:0]            period;
		thr_pkg::thr_ext_t      ext_sel;
		logic                   active;
		logic                   under;
		logic                   prim;
		logic                   des;
		logic                   silent_now;
		logic                   take;
		logic [thr_pkg::DW-1:0] ext_new;
		logic [thr_pkg::DW-1:0] cfg_thr;
		logic [thr_pkg::DW-1:0] hyst;
		logic [thr_pkg::DW-1:0] thr;
		logic [thr_pkg::DW-1:0] lo;
		logic [thr_pkg::DW:0]   hi;
		logic [11:0]            dly;
		logic [thr_pkg::DW-1:0] ext_ff;
		logic                   ext_valid_ff;
		logic                   upd_ff;
		logic                   cond_ff;
		thr_pkg::thr_dly_t      st_ff;
		logic [11:0]            tmr_ff;
		logic                   obj_ff;
		logic                   chg_ff;
		logic [11:0]            cyc_cnt_ff;
		logic                   due_ff;
		logic                   send_ff;
		logic                   val_ff;

		assign cfg_w    = cfg_bus.cfg[1 + 2 * g];
		assign tim_w    = cfg_bus.cfg[2 + 2 * g];
		assign idx      = cfg_w[thr_pkg::CFG_IDX_LSB +: 5];
		assign ext_sel  = thr_pkg::thr_ext_t'(cfg_w[thr_pkg::CFG_EXT_LSB +: 2]);
		assign mode     = cfg_w[thr_pkg::CFG_MODE_LSB +: 4];
		assign on_code  = tim_w[thr_pkg::TIM_ON_LSB +: 4];
		assign off_code = tim_w[thr_pkg::TIM_OFF_LSB +: 4];
		assign soc      = tim_w[thr_pkg::TIM_SOC_BIT];
		assign cyc      = tim_w[thr_pkg::TIM_CYC_LSB +: 7];

		// instance g runs only when enough thresholds are chosen
		assign active = limits > 2'(g);

		// configured threshold, index clamped to the legal steps
		assign idx_c   = (idx < thr_pkg::THR_IDX_MIN) ? thr_pkg::THR_IDX_MIN :
			(idx > thr_pkg::THR_IDX_MAX) ? thr_pkg::THR_IDX_MAX : idx;
		assign cfg_thr = 16'(idx_c) * thr_pkg::LUX_STEP;
		assign hyst    = thr_pkg::thr_hyst(cfg_w[thr_pkg::CFG_HYST_LSB +: 4]);

		// external value wins once one has been received
		assign thr = (ext_sel != thr_pkg::THR_EXT_NONE && ext_valid_ff) ? ext_ff : cfg_thr;
		assign lo  = (thr > hyst) ? 16'(thr - hyst) : 16'h0000;
		assign hi  = {1'b0, thr} + {1'b0, hyst};

		// mode bit 1 picks direction, bit 0 the chosen value, top bits the silent side
		assign under = mode[1];
		assign prim  = ~mode[0];
		assign des   = cond_ff ? prim : ~prim;

		// silent side is judged on the applied value
		assign silent_now = (mode[3:2] == 2'h1 && obj_ff != prim) ||
			(mode[3:2] == 2'h2 && obj_ff == prim);

		always_comb begin
			take    = 1'b0;
			ext_new = ext_value;
			case (ext_sel)
				thr_pkg::THR_EXT_16: begin
					take = ext_wr[g];
				end
				thr_pkg::THR_EXT_8: begin
					take    = ext_wr[g];
					ext_new = {8'h00, ext_value[7:0]};
				end
				thr_pkg::THR_EXT_TEACH: begin
					take    = teach_sw[g];
					ext_new = meas_ff;
				end
				default: begin
					take = 1'b0;
				end
			endcase
		end

		// download drops the external value; a value in the same cycle still counts
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				ext_ff       <= '0;
				ext_valid_ff <= 1'b0;
				upd_ff       <= 1'b0;
			end else begin
				upd_ff <= take || load_ff;
				if (load_ff) begin
					ext_valid_ff <= 1'b0;
				end
				if (take) begin
					ext_ff       <= ext_new;
					ext_valid_ff <= 1'b1;
				end
			end
		end

		// comparator re-evaluated on a new measurement or threshold
		always_ff @(posedge ref_clk) begin
			if (rst || !active || load_ff) begin
				cond_ff <= 1'b0;
			end else if (meas_new_ff || upd_ff) begin
				if (!under) begin
					if (meas_ff > thr) begin
						cond_ff <= 1'b1;
					end else if (meas_ff < lo) begin
						cond_ff <= 1'b0;
					end
				end else begin
					if (meas_ff < thr) begin
						cond_ff <= 1'b1;
					end else if ({1'b0, meas_ff} > hi) begin
						cond_ff <= 1'b0;
					end
				end
			end
		end

		// delay picked by the direction of the change
		assign dly = thr_pkg::thr_delay_s(des ? on_code : off_code);

		// obj_ff keeps the old value until the delay ends
		always_ff @(posedge ref_clk) begin
			if (rst || !active) begin
				st_ff  <= thr_pkg::THR_IDLE;
				tmr_ff <= 12'h000;
				obj_ff <= 1'b0;
				chg_ff <= 1'b0;
			end else begin
				chg_ff <= 1'b0;
				case (st_ff)
					thr_pkg::THR_IDLE: begin
						if (des != obj_ff && dly == 12'h000) begin
							obj_ff <= des;
							chg_ff <= 1'b1;
						end else if (des != obj_ff) begin
							st_ff  <= thr_pkg::THR_WAIT;
							tmr_ff <= 12'h000;
						end
					end
					thr_pkg::THR_WAIT: begin
						if (des == obj_ff) begin
							st_ff <= thr_pkg::THR_IDLE;
						end else if (sec_tick_ff && 12'(tmr_ff + 1'b1) >= dly) begin
							obj_ff <= des;
							chg_ff <= 1'b1;
							st_ff  <= thr_pkg::THR_IDLE;
						end else if (sec_tick_ff) begin
							tmr_ff <= 12'(tmr_ff + 1'b1);
						end
					end
					default: begin
						st_ff <= thr_pkg::THR_IDLE;
					end
				endcase
			end
		end

		// period in seconds, setting held to its top value
		assign cyc_c  = (cyc > thr_pkg::CYC_MAX) ? thr_pkg::CYC_MAX : cyc;
		assign period = 12'(cyc_c) * thr_pkg::CYC_UNIT_S;

		// cycle timer restarts after each cyclic slot
		always_ff @(posedge ref_clk) begin
			if (rst || !active || cyc_c == 7'h00) begin
				cyc_cnt_ff <= 12'h000;
				due_ff     <= 1'b0;
			end else begin
				due_ff <= 1'b0;
				if (sec_tick_ff && 12'(cyc_cnt_ff + 1'b1) >= period) begin
					cyc_cnt_ff <= 12'h000;
					due_ff     <= 1'b1;
				end else if (sec_tick_ff) begin
					cyc_cnt_ff <= 12'(cyc_cnt_ff + 1'b1);
				end
			end
		end

		// telegram only on enabled, non-silent events
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				send_ff <= 1'b0;
				val_ff  <= 1'b0;
			end else begin
				send_ff <= active && !silent_now && ((chg_ff && soc) || due_ff);
				val_ff  <= obj_ff;
			end
		end

		assign obj_send[g]  = send_ff;
		assign obj_value[g] = val_ff;
		assign obj_v[g]     = obj_ff;
		assign cond_v[g]    = cond_ff;
		assign extv_v[g]    = ext_valid_ff;
		assign wait_v[g]    = (st_ff == thr_pkg::THR_WAIT);
		assign thr_v[g]     = thr;
	end
endmodule
`default_nettype wire

/* File: pkg/thr_pkg.sv */
package thr_pkg;
	// clock and one-second tick
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned SEC_TIME_NS   = 1000000000;
	localparam int unsigned SEC_CYCLES    = SEC_TIME_NS / CLK_PERIOD_NS;

	// data and address widths, instance count
	localparam int unsigned DW         = 16;
	localparam int unsigned AW         = 3;
	localparam int unsigned THR_COUNT  = 2;
	localparam int unsigned CFG_WORDS  = 5;
	localparam int unsigned STAT_WORDS = 3;

	// register word indices
	localparam logic [2:0] REG_CTRL      = 3'h0;
	localparam logic [2:0] REG_THR1_CFG  = 3'h1;
	localparam logic [2:0] REG_THR1_TIME = 3'h2;
	localparam logic [2:0] REG_THR2_CFG  = 3'h3;
	localparam logic [2:0] REG_THR2_TIME = 3'h4;
	localparam logic [2:0] REG_STATUS    = 3'h5;
	localparam logic [2:0] REG_THR1_EFF  = 3'h6;
	localparam logic [2:0] REG_THR2_EFF  = 3'h7;

	// control word fields
	localparam int unsigned CTRL_LIMITS_LSB = 0;
	localparam int unsigned CTRL_DIFF_LSB   = 2;
	localparam int unsigned CTRL_LOAD_BIT   = 8;

	// threshold config word fields
	localparam int unsigned CFG_IDX_LSB  = 0;
	localparam int unsigned CFG_EXT_LSB  = 5;
	localparam int unsigned CFG_HYST_LSB = 8;
	localparam int unsigned CFG_MODE_LSB = 12;

	// threshold timing word fields
	localparam int unsigned TIM_ON_LSB  = 0;
	localparam int unsigned TIM_OFF_LSB = 4;
	localparam int unsigned TIM_SOC_BIT = 8;
	localparam int unsigned TIM_CYC_LSB = 9;

	// values after reset
	localparam logic [15:0] CTRL_RST      = 16'h0000;
	localparam logic [15:0] CFG_RST       = 16'h0001;
	localparam logic [15:0] TIME_RST      = 16'h0000;
	localparam logic [15:0] RANGE_TOP_RST = 16'h02a2;

	// scaling and limits
	localparam logic [15:0] LUX_STEP     = 16'h0019;
	localparam logic [4:0]  THR_IDX_MIN  = 5'h01;
	localparam logic [4:0]  THR_IDX_MAX  = 5'h1a;
	localparam logic [6:0]  CYC_MAX      = 7'h78;
	localparam logic [11:0] CYC_UNIT_S   = 12'h00a;
	localparam logic [3:0]  MEAS_DELAY_S = 4'ha;
	localparam logic [31:0] DIFF_PM0     = 32'h0000_0005;
	localparam logic [31:0] DIFF_PM1     = 32'h0000_000a;
	localparam logic [31:0] DIFF_PM2     = 32'h0000_001e;
	localparam logic [31:0] DIFF_PM3     = 32'h0000_0064;
	localparam logic [31:0] PM_DIV       = 32'h0000_03e8;

	typedef enum logic [1:0] {THR_EXT_NONE, THR_EXT_16, THR_EXT_8, THR_EXT_TEACH} thr_ext_t;
	typedef enum logic       {THR_IDLE, THR_WAIT} thr_dly_t;

	// delay codes in seconds: none, 1s..30s, 1, 3, 5, 10, 15, 30, 60 min
	function automatic logic [11:0] thr_delay_s(input logic [3:0] code);
		case (code)
			4'h1: thr_delay_s = 12'h001;
			4'h2: thr_delay_s = 12'h003;
			4'h3: thr_delay_s = 12'h005;
			4'h4: thr_delay_s = 12'h00a;
			4'h5: thr_delay_s = 12'h00f;
			4'h6: thr_delay_s = 12'h01e;
			4'h7: thr_delay_s = 12'h03c;
			4'h8: thr_delay_s = 12'h0b4;
			4'h9: thr_delay_s = 12'h12c;
			4'ha: thr_delay_s = 12'h258;
			4'hb: thr_delay_s = 12'h384;
			4'hc: thr_delay_s = 12'h708;
			4'hd: thr_delay_s = 12'he10;
			default: thr_delay_s = 12'h000;
		endcase
	endfunction

	// hysteresis codes: none, 5, 10, 25, 50, then 100 to 600 in 50s
	function automatic logic [15:0] thr_hyst(input logic [3:0] code);
		case (code)
			4'h0: thr_hyst = 16'h0000;
			4'h1: thr_hyst = 16'h0005;
			4'h2: thr_hyst = 16'h000a;
			4'h3: thr_hyst = 16'h0019;
			4'h4: thr_hyst = 16'h0032;
			default: thr_hyst = 16'(({12'h000, code} - 16'h0003) * 16'h0032);
		endcase
	endfunction

	function automatic logic [15:0] thr_rst_word(input int unsigned i);
		if (i == 0) begin
			thr_rst_word = CTRL_RST;
		end else if (i % 2 == 1) begin
			thr_rst_word = CFG_RST;
		end else begin
			thr_rst_word = TIME_RST;
		end
	endfunction
endpackage

/* File: pkg/thr_cfg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface thr_cfg_if;
	logic                                                wr;
	logic                                                rd;
	logic [thr_pkg::AW-1:0]                              addr;
	logic [thr_pkg::DW-1:0]                              wdata;
	logic [thr_pkg::DW-1:0]                              rdata;
	wire logic [thr_pkg::CFG_WORDS-1:0][thr_pkg::DW-1:0] cfg;
	logic [thr_pkg::STAT_WORDS-1:0][thr_pkg::DW-1:0]     stat;

	modport core (output wr, rd, addr, wdata, stat, input rdata, cfg);
	modport mem (input wr, rd, addr, wdata, stat, output rdata, cfg);
endinterface
`default_nettype wire

/* File: rtl/thr_regfile.sv */
`timescale 1ns/1ps
`default_nettype none
module thr_regfile (
	input wire logic ref_clk,
	input wire logic rst,
	thr_cfg_if.mem   bus
);
	// one register per configuration word
	for (genvar i = 0; i < thr_pkg::CFG_WORDS; i++) begin : g_word
		logic [thr_pkg::DW-1:0] word_ff;
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				word_ff <= thr_pkg::thr_rst_word(i);
			end else if (bus.wr && bus.addr == thr_pkg::AW'(i)) begin
				word_ff <= bus.wdata;
			end
		end
		assign bus.cfg[i] = word_ff;
	end

	// registered read, zero outside the answer cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bus.rdata <= '0;
		end else if (!bus.rd) begin
			bus.rdata <= '0;
		end else if (bus.addr < thr_pkg::AW'(thr_pkg::CFG_WORDS)) begin
			bus.rdata <= bus.cfg[bus.addr];
		end else begin
			bus.rdata <= bus.stat[thr_pkg::AW'(bus.addr - thr_pkg::AW'(thr_pkg::CFG_WORDS))];
		end
	end
endmodule
`default_nettype wire

/* File: verification/thr_reporter_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module thr_reporter_sva #(
	parameter int unsigned SEC_CYCLES = 20
) (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [2:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [1:0]  obj_send,
	input wire logic        meas_send,
	input wire logic [15:0] meas_out
);
	localparam int GAP_MIN = 9 * SEC_CYCLES - 1;
	logic [3:0]  ctl_ff;
	logic [7:0]  tim_ff;
	logic [3:0]  age_ff;
	logic [31:0] gap_ff;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// shadow of control and timing words as written
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctl_ff <= 4'h0;
			tim_ff <= 8'h00;
		end else if (reg_wr && reg_addr == thr_pkg::REG_CTRL) begin
			ctl_ff <= reg_wdata[3:0];
		end else if (reg_wr && reg_addr == thr_pkg::REG_THR1_TIME) begin
			tim_ff <= reg_wdata[15:8];
		end
	end
	// settling age, pending telegrams may still leave right after a write
	always_ff @(posedge ref_clk) begin
		if (rst || reg_wr) begin
			age_ff <= 4'h0;
		end else if (age_ff != 4'hf) begin
			age_ff <= age_ff + 4'h1;
		end
	end
	// cycles since the last measured-value telegram
	always_ff @(posedge ref_clk) begin
		if (rst || meas_send) begin
			gap_ff <= 32'h0000_0000;
		end else if (gap_ff != 32'hffff_ffff) begin
			gap_ff <= gap_ff + 32'h0000_0001;
		end
	end
	sequence s_ctl_rd;
		reg_rd && reg_addr == thr_pkg::REG_CTRL;
	endsequence
	property p_ctl_rd;
		s_ctl_rd |=> reg_rdata[8] == 1'b0 && reg_rdata[3:0] == $past(ctl_ff);
	endproperty
	property p_rd_idle;
		!reg_rd |=> reg_rdata == 16'h0000;
	endproperty
	property p_pulse;
		obj_send != 2'h0 |=> (obj_send & $past(obj_send)) == 2'h0;
	endproperty
	property p_off_all;
		ctl_ff[1:0] == 2'h0 && age_ff == 4'hf |-> obj_send == 2'h0;
	endproperty
	property p_off_two;
		ctl_ff[1:0] == 2'h1 && age_ff == 4'hf |-> !obj_send[1];
	endproperty
	property p_never;
		tim_ff == 8'h00 && age_ff == 4'hf |-> !obj_send[0];
	endproperty
	property p_gap;
		meas_send |-> gap_ff >= GAP_MIN;
	endproperty
	property p_hold;
		!meas_send |-> $stable(meas_out);
	endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("control read wrong");
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	a_pulse: assert property (p_pulse) else $error("telegram pulse too long");
	a_off_all: assert property (p_off_all) else $error("telegram while unused");
	a_off_two: assert property (p_off_two) else $error("second unused sends");
	a_never: assert property (p_never) else $error("telegram while disabled");
	a_gap: assert property (p_gap) else $error("measured value too soon");
	a_hold: assert property (p_hold) else $error("measured value moved");
endmodule
bind thr_reporter thr_reporter_sva #(.SEC_CYCLES(SEC_CYCLES)) i_thr_reporter_sva (
	.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .obj_send(obj_send),
	.meas_send(meas_send), .meas_out(meas_out));
`default_nettype wire

/* File: verification/thr_bus_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module thr_bus_peer (
	input  wire logic        ref_clk,
	input  wire logic [1:0]  obj_send,
	input  wire logic [1:0]  obj_value,
	output logic      [1:0]  ext_wr,
	output logic      [15:0] ext_value
);
	logic rx_q[$];
	int   rx_n[2];
	// idle value line before any telegram
	initial begin
		ext_wr = 2'h0;
		ext_value = 16'h0000;
	end
	// telegrams counted, first object kept in order
	always @(posedge ref_clk) begin
		for (int g = 0; g < 2; g++) if (obj_send[g] === 1'b1) rx_n[g]++;
		if (obj_send[0] === 1'b1) rx_q.push_back(obj_value[0]);
	end
	task automatic put_ext(input int g, input logic [15:0] v);
		@(posedge ref_clk);
		ext_wr[g] <= 1'b1;
		ext_value <= v;
		@(posedge ref_clk);
		ext_wr <= 2'h0;
		ext_value <= ~v; // released line shows no stale value
	endtask
endmodule
`default_nettype wire

/* File: verification/thr_reporter_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module thr_reporter_bench;
	localparam int unsigned SC = 20;
	logic        ref_clk    = 1'b0;
	logic        rst        = 1'b1;
	logic [2:0]  reg_addr   = 3'h0;
	logic [15:0] reg_wdata  = 16'h0000;
	logic        reg_wr     = 1'b0;
	logic        reg_rd     = 1'b0;
	logic        meas_valid = 1'b0;
	logic [15:0] meas_value = 16'h0000;
	logic [1:0]  teach_sw   = 2'h0;
	logic [31:0] seed       = 32'h17c2c1a5;
	logic [15:0] reg_rdata;
	logic [1:0]  ext_wr;
	logic [15:0] ext_value;
	logic [1:0]  obj_send;
	logic [1:0]  obj_value;
	logic        meas_send;
	logic [15:0] meas_out;
	int          err_total  = 0;
	int          checks     = 0;
	always #25 ref_clk = ~ref_clk;
	thr_reporter #(.SEC_CYCLES(SC)) i_thr_reporter (.ref_clk(ref_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .meas_valid(meas_valid), .meas_value(meas_value),
		.ext_wr(ext_wr), .ext_value(ext_value), .teach_sw(teach_sw), .obj_send(obj_send),
		.obj_value(obj_value), .meas_send(meas_send), .meas_out(meas_out));
	thr_bus_peer i_thr_bus_peer (.ref_clk(ref_clk), .obj_send(obj_send),
		.obj_value(obj_value), .ext_wr(ext_wr), .ext_value(ext_value));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic end_of_test();
		if (err_total == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rc(input logic [2:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic ms(input logic [15:0] v);
		@(posedge ref_clk);
		meas_valid <= 1'b1;
		meas_value <= v;
		@(posedge ref_clk);
		meas_valid <= 1'b0;
	endtask
	// wait for a telegram, the carried value must hold v meanwhile
	task automatic wt(input int lim, input logic v, output int n);
		n = 0;
		while (obj_send[0] !== 1'b1 && n < lim) begin
			@(posedge ref_clk);
			#1 n++;
			if (obj_send[0] !== 1'b1) chk(16'(obj_value[0]), 16'(v));
		end
	endtask
	task automatic wm(input int lim, output int n);
		n = 0;
		while (meas_send !== 1'b1 && n < lim) begin
			@(posedge ref_clk);
			#1 n++;
		end
	endtask
	// reference comparator with hysteresis, expected telegrams queued
	task automatic run_mode(input logic [3:0] md);
		int   cnd, o, v, ch;
		logic q[$];
		cnd = md[1] ? meas_value < 100 : meas_value > 100; // download re-judges the last value
		ch = !md[0];
		wr(thr_pkg::REG_THR1_TIME, 16'h0000);
		wr(thr_pkg::REG_THR1_CFG, {md, 4'h2, 3'h0, 5'h04});
		wr(thr_pkg::REG_CTRL, 16'h0101);
		repeat (10) @(posedge ref_clk);
		wr(thr_pkg::REG_THR1_TIME, 16'h0100);
		i_thr_bus_peer.rx_q.delete();
		repeat (20) begin
			seed = lfsr(seed);
			v = int'(seed[6:0]) * 2 + 1; // odd values never hit a boundary
			ms(16'(v));
			repeat (8) @(posedge ref_clk);
			o = cnd;
			if (md[1] ? v < 100 : v > 100) cnd = 1;
			else if (md[1] ? v > 110 : v < 90) cnd = 0;
			if (cnd != o && md[3:2] != (cnd ? 2'h2 : 2'h1)) q.push_back(cnd ? ch : !ch);
		end
		chk(16'(i_thr_bus_peer.rx_q.size()), 16'(q.size()));
		foreach (q[i]) chk(16'(i_thr_bus_peer.rx_q[i]), 16'(q[i]));
	endtask
	// hang guard, far beyond the expected run
	initial begin
		#1500000;
		err_total++;
		end_of_test();
	end
	initial begin
		int          n, t, e;
		int          ix[4]  = '{0, 4, 26, 31};
		logic [3:0]  mds[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'ha};
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		// values after reset, none in use
		for (int a = 0; a < 5; a++)
			rc(3'(a), a == 0 ? thr_pkg::CTRL_RST : a % 2 ? thr_pkg::CFG_RST : thr_pkg::TIME_RST);
		foreach (ix[i]) begin
			e = (ix[i] < 1 ? 1 : ix[i] > 26 ? 26 : ix[i]) * 25;
			wr(thr_pkg::REG_THR1_CFG, 16'(ix[i]));
			rc(thr_pkg::REG_THR1_EFF, 16'(e));
		end
		wr(thr_pkg::REG_CTRL, 16'h0001);
		wr(thr_pkg::REG_THR1_CFG, 16'h0024);
		i_thr_bus_peer.put_ext(0, 16'h00c8);
		rc(thr_pkg::REG_THR1_EFF, 16'h00c8);
		wr(thr_pkg::REG_CTRL, 16'h0101);
		rc(thr_pkg::REG_THR1_EFF, 16'h0064);
		wr(thr_pkg::REG_THR1_CFG, 16'h0044);
		i_thr_bus_peer.put_ext(0, 16'h1234);
		rc(thr_pkg::REG_THR1_EFF, 16'h0034);
		wr(thr_pkg::REG_THR1_CFG, 16'h0064);
		ms(16'h0141);
		@(posedge ref_clk);
		teach_sw <= 2'h1;
		@(posedge ref_clk);
		teach_sw <= 2'h0;
		i_thr_bus_peer.put_ext(0, 16'h0077); // ignored while teaching
		rc(thr_pkg::REG_THR1_EFF, 16'h0141);
		rc(thr_pkg::REG_THR2_EFF, 16'h0019);
		foreach (mds[i]) run_mode(mds[i]);
		// three second delays, one second tick jitter
		wr(thr_pkg::REG_THR1_CFG, 16'h0204);
		ms(16'h0033); // start below the band so the download leaves it off
		wr(thr_pkg::REG_CTRL, 16'h0101);
		wr(thr_pkg::REG_THR1_TIME, 16'h0122);
		ms(16'h0097);
		wt(100, 1'b0, n);
		chk(16'(n >= 36 && n <= 66), 16'h0001);
		ms(16'h0033);
		wt(100, 1'b1, n);
		chk(16'(n >= 36 && n <= 66), 16'h0001);
		wr(thr_pkg::REG_THR1_TIME, 16'h0200);
		wt(260, 1'b0, n);
		#50; // step past the first slot's pulse before timing the next
		wt(260, 1'b0, n);
		chk(16'(n), 16'(10 * SC - 1));
		chk(16'(obj_value[0]), 16'h0000);
		wr(thr_pkg::REG_THR1_TIME, 16'h0000);
		t = i_thr_bus_peer.rx_n[0];
		ms(16'h0097);
		repeat (120) @(posedge ref_clk);
		chk(16'(i_thr_bus_peer.rx_n[0] - t), 16'h0000);
		// second threshold with its own state
		wr(thr_pkg::REG_CTRL, 16'h0002);
		wr(thr_pkg::REG_THR2_CFG, 16'h0004);
		wr(thr_pkg::REG_THR2_TIME, 16'h0100);
		t = i_thr_bus_peer.rx_n[1];
		ms(16'h00c9);
		repeat (8) @(posedge ref_clk);
		chk(16'(i_thr_bus_peer.rx_n[1] - t), 16'h0001);
		chk(16'(obj_value[1]), 16'h0001);
		// step is a tenth of range top
		e = int'(thr_pkg::RANGE_TOP_RST) * 100 / 1000;
		wr(thr_pkg::REG_CTRL, 16'h000d);
		ms(16'h01f4);
		wm(450, n);
		chk(meas_out, 16'h01f4);
		@(posedge ref_clk);
		ms(16'(500 + e - 1));
		wm(450, n);
		chk(16'(n), 16'(450));
		ms(16'(500 + e));
		wm(450, n);
		chk(meas_out, 16'(500 + e));
		end_of_test();
	end
endmodule
`default_nettype wire
